//--- sadc_conv_timer.sv
// sadc_conv_timer: internal conversion clock, one bit step per cycle
// assumes start and abort are single-cycle pulses from the sequencer
`timescale 1ns/1ps
module sadc_conv_timer (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // control
  input  wire logic                     start_in,
  input  wire logic                     abort_in,
  // step outputs
  output logic                          step_out,
  output logic [3:0]                    bit_idx_out,
  output logic                          last_out
);

  logic                          running;
  logic [sadc_pkg::CNT_W-1:0]    cnt;
  logic                          next_running;
  logic [sadc_pkg::CNT_W-1:0]    next_cnt;

  localparam logic [sadc_pkg::CNT_W-1:0] LAST_CNT =
    sadc_pkg::CNT_W'(sadc_pkg::CONV_CYCLES - 1);

  always_comb begin
    next_running = running;
    next_cnt     = cnt;
    if (abort_in) begin
      next_running = 1'b0;
      next_cnt     = '0;
    end else if (start_in) begin
      next_running = 1'b1;
      next_cnt     = '0;
    end else if (running) begin
      if (cnt == LAST_CNT) begin
        next_running = 1'b0;
        next_cnt     = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running <= 1'b0;
      cnt     <= '0;
    end else begin
      running <= next_running;
      cnt     <= next_cnt;
    end
  end

  // msb decided first
  assign step_out    = running;
  assign bit_idx_out = 4'hf - cnt[3:0];
  assign last_out    = running && (cnt == LAST_CNT);

endmodule : sadc_conv_timer

//--- sadc_host_model.sv
// sadc_host_model: host that starts conversions and reads the pins
// assumes the device pins share clk_in
`timescale 1ns/1ps
module sadc_host_model (
  // clock
  input wire logic        clk_in,
  // device pins
  input wire logic        busy_in,
  input wire logic        oe_in,
  input wire logic [15:0] data_in,
  output logic            convert_start_n_out,
  output logic            select_n_out,
  output logic            read_n_out,
  output logic            byte_sel_out
);
  initial begin
    convert_start_n_out = 1'b1;
    select_n_out = 1'b1;
    read_n_out = 1'b1;
    byte_sel_out = 1'b0;
  end
  // gap of sampling cycles, then a one-cycle low start
  task automatic start(input int gap);
    repeat (gap) @(posedge clk_in);
    select_n_out <= 1'b0;
    convert_start_n_out <= 1'b0;
    @(posedge clk_in);
    convert_start_n_out <= 1'b1;
  endtask : start
  // busy falling marks completion
  task automatic wait_done(output int cyc);
    cyc = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      if (busy_in !== 1'b1) break;
      cyc++;
    end
  endtask : wait_done
  // word or byte read
  task automatic read_pins(input logic b, output logic [15:0] d);
    select_n_out <= 1'b0;
    read_n_out <= 1'b0;
    byte_sel_out <= b;
    repeat (2) @(posedge clk_in);
    d = oe_in ? data_in : 16'hxxxx;
    select_n_out <= 1'b1;
    read_n_out <= 1'b1;
    @(posedge clk_in);
  endtask : read_pins
endmodule : sadc_host_model

//--- sadc_pkg.sv
// sadc_pkg: constants and types of the conversion sequencer and readout
// assumes a 25 MHz system clock and a 32-bit avalon-mm register port
package sadc_pkg;

  localparam int CLK_HZ       = 25000000;
  localparam int CONV_TIME_NS = 650;
  localparam int ACQ_TIME_NS  = 150;
  // longest time rounds down, least time rounds up
  localparam int CONV_CYCLES  = (CONV_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int ACQ_CYCLES   =
    (ACQ_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;

  localparam int RES_W  = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 5;

  // register byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_STATE  = 4'hc;

  // status and mask bit positions
  localparam int EVT_DONE  = 0;
  localparam int EVT_EARLY = 1;
  localparam int EVT_ABORT = 2;
  localparam int EVT_W     = 3;

  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;

  typedef enum logic [0:0] {
    SADC_SAMPLE  = 1'b0,
    SADC_CONVERT = 1'b1
  } sadc_state_e;

  typedef struct packed {
    logic abort;
    logic early;
    logic done;
  } sadc_evt_s;

endpackage : sadc_pkg

//--- sadc_readout.sv
// sadc_readout: conversion sequencer and parallel result port
// assumes pins synchronous to clk_in; sample_value_in is the digitised
// difference of the two analog inputs while they are connected
// Summary of operation
// - a low reset aborts any conversion and clears the result latches.
// - with select low, read low enables the last result onto the pins.
// - conversion steps come from an internal clock, none from outside.
// - a conversion ends within 650 ns, allowing 1.25 MHz throughput.
// - a start enters hold mode and freezes the input difference.
// - the analog inputs stay disconnected for the whole conversion.
// - a falling start with select low in sample mode begins a conversion; busy rises.
// - byte select high puts the low byte high and ones on low pins.
// - the result is straight binary, one step equal to ref over 65536.
// - unless select and read are both low the data pins float.
`timescale 1ns/1ps
module sadc_readout (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     reset_n_in,
  // converter pins
  input  wire logic                     convert_start_n_in,
  input  wire logic                     select_n_in,
  input  wire logic                     read_n_in,
  input  wire logic                     byte_sel_in,
  output logic                          busy_out,
  output logic [15:0]                   result_bus_out,
  output logic                          result_bus_oe_out,
  // analog front end
  input  wire logic [15:0]              sample_value_in,
  output logic                          input_connect_out,
  output logic                          hold_out,
  // avalon-mm slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // interrupt
  output logic                          irq_out
);

  // reset release
  logic                          rst_meta;
  logic                          rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // sequencer state
  sadc_pkg::sadc_state_e         state;
  sadc_pkg::sadc_state_e         next_state;
  logic                          start_prev;
  logic [15:0]                   held;
  logic [15:0]                   next_held;
  logic [15:0]                   work;
  logic [15:0]                   next_work;
  logic [15:0]                   result;
  logic [15:0]                   next_result;
  logic [2:0]                    acq_cnt;
  logic [2:0]                    next_acq_cnt;
  sadc_pkg::sadc_evt_s           evt;
  logic                          start_fall;
  logic                          conv_start;
  logic                          conv_abort;
  logic                          step;
  logic [3:0]                    bit_idx;
  logic                          last;
  logic [15:0]                   trial;

  localparam logic [2:0] ACQ_MIN = 3'(sadc_pkg::ACQ_CYCLES);

  assign start_fall = start_prev && !convert_start_n_in && !select_n_in;
  assign conv_start = start_fall && (state == sadc_pkg::SADC_SAMPLE);
  // a new start during conversion acts as a self-clearing reset
  assign conv_abort = start_fall && (state == sadc_pkg::SADC_CONVERT);

  sadc_conv_timer u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .start_in    (conv_start),
    .abort_in    (conv_abort),
    .step_out    (step),
    .bit_idx_out (bit_idx),
    .last_out    (last)
  );

  always_comb begin
    next_state   = state;
    next_held    = held;
    next_work    = work;
    next_result  = result;
    next_acq_cnt = acq_cnt;
    trial        = work | (16'h0001 << bit_idx);
    evt          = '0;
    if (state == sadc_pkg::SADC_SAMPLE && acq_cnt != ACQ_MIN) begin
      next_acq_cnt = acq_cnt + 3'h1;
    end
    if (conv_start) begin
      next_state = sadc_pkg::SADC_CONVERT;
      next_held  = sample_value_in;
      next_work  = 16'h0000;
      evt.early  = (acq_cnt != ACQ_MIN);
    end else if (conv_abort) begin
      next_state   = sadc_pkg::SADC_SAMPLE;
      next_acq_cnt = 3'h0;
      evt.abort    = 1'b1;
    end else if (step) begin
      // straight binary successive approximation
      if (held >= trial) begin
        next_work = trial;
      end
      if (last) begin
        next_state   = sadc_pkg::SADC_SAMPLE;
        next_acq_cnt = 3'h0;
        next_result  = (held >= trial) ? trial : work;
        evt.done     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state      <= sadc_pkg::SADC_SAMPLE;
      start_prev <= 1'b1;
      held       <= 16'h0000;
      work       <= 16'h0000;
      result     <= sadc_pkg::RESULT_RST;
      acq_cnt    <= 3'h0;
    end else begin
      state      <= next_state;
      start_prev <= convert_start_n_in;
      held       <= next_held;
      work       <= next_work;
      result     <= next_result;
      acq_cnt    <= next_acq_cnt;
    end
  end

  // pin outputs
  logic                          next_busy;
  logic                          next_connect;
  logic [15:0]                   next_bus;
  logic                          next_oe;

  always_comb begin
    next_busy    = (next_state == sadc_pkg::SADC_CONVERT);
    next_connect = (next_state == sadc_pkg::SADC_SAMPLE);
    next_oe      = !select_n_in && !read_n_in;
    if (byte_sel_in) begin
      next_bus = {next_result[7:0], sadc_pkg::BYTE_ONES};
    end else begin
      next_bus = next_result;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_out          <= 1'b0;
      input_connect_out <= 1'b1;
      hold_out          <= 1'b0;
      result_bus_out    <= sadc_pkg::RESULT_RST;
      result_bus_oe_out <= 1'b0;
    end else begin
      busy_out          <= next_busy;
      input_connect_out <= next_connect;
      hold_out          <= next_busy;
      result_bus_out    <= next_bus;
      result_bus_oe_out <= next_oe;
    end
  end

  // register port and interrupt
  logic [2:0]                    status;
  logic [2:0]                    next_status;
  logic [2:0]                    mask;
  logic [2:0]                    next_mask;
  logic                          next_wait;
  logic [31:0]                   next_rdata;
  logic                          wr_take;
  logic [2:0]                    clr;

  assign wr_take = avs_write && !avs_waitrequest;

  always_comb begin
    clr = '0;
    if (wr_take && avs_address == sadc_pkg::ADDR_STATUS
        && avs_byteenable[0]) begin
      clr = avs_writedata[2:0];
    end
    // set wins over clear
    next_status = (status & ~clr) | evt;
    next_mask   = mask;
    if (wr_take && avs_address == sadc_pkg::ADDR_MASK
        && avs_byteenable[0]) begin
      next_mask = avs_writedata[2:0];
    end
    // one wait state per request
    next_wait  = !((avs_read || avs_write) && avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        sadc_pkg::ADDR_STATUS: next_rdata = {29'h0, status};
        sadc_pkg::ADDR_MASK:   next_rdata = {29'h0, mask};
        sadc_pkg::ADDR_RESULT: next_rdata = {16'h0, result};
        sadc_pkg::ADDR_STATE:  next_rdata = {29'h0, acq_cnt == ACQ_MIN,
                                             input_connect_out, busy_out};
        default:               next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status          <= 3'h0;
      mask            <= 3'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      irq_out         <= 1'b0;
    end else begin
      status          <= next_status;
      mask            <= next_mask;
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
      irq_out         <= |(next_status & next_mask);
    end
  end

endmodule : sadc_readout

//--- sadc_readout_monitor.sv
// sadc_readout_monitor: pin and bus checks
// assumes binding to sadc_readout on clk_in
`timescale 1ns/1ps
module sadc_readout_monitor (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // pins
  input wire logic        convert_start_n_in,
  input wire logic        select_n_in,
  input wire logic        read_n_in,
  input wire logic        byte_sel_in,
  input wire logic        busy_out,
  input wire logic [15:0] result_bus_out,
  input wire logic        result_bus_oe_out,
  input wire logic        input_connect_out,
  input wire logic        hold_out,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [4:0] busy_cnt;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      busy_cnt <= 5'h00;
    else
      busy_cnt <= busy_out ? busy_cnt + 5'h01 : 5'h00;
  end
  AST_RST: assert property (@(posedge clk_in) disable iff (1'b0)
    !reset_n_in |-> !busy_out && result_bus_out == 16'h0000)
    else $error("outputs not cleared in reset");
  AST_START: assert property (
    $fell(convert_start_n_in) && !select_n_in && !busy_out |=> busy_out)
    else $error("busy did not rise");
  AST_BUSY_MAX: assert property (busy_cnt <= 5'h10)
    else $error("conversion too long");
  AST_HOLD: assert property (hold_out == busy_out)
    else $error("hold differs from busy");
  AST_DISC: assert property (busy_out |-> !input_connect_out)
    else $error("inputs connected in conversion");
  AST_OE_ON: assert property (
    !$past(select_n_in) && !$past(read_n_in) |-> result_bus_oe_out)
    else $error("bus not enabled");
  AST_OE_OFF: assert property (
    $past(select_n_in) || $past(read_n_in) |-> !result_bus_oe_out)
    else $error("bus not released");
  AST_BYTE: assert property (
    result_bus_oe_out && $past(byte_sel_in) |-> result_bus_out[7:0] == 8'hff)
    else $error("low pins not ones");
  AST_KEEP: assert property (
    busy_out && $past(busy_out) && $stable(byte_sel_in) |=> busy_out
    |-> $stable(result_bus_out))
    else $error("result changed in conversion");
  AST_WAIT: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  COV_CONV: cover property ($fell(busy_out));
  COV_BYTE: cover property (result_bus_oe_out && $past(byte_sel_in));
  COV_BUS: cover property (!avs_waitrequest);
endmodule : sadc_readout_monitor

bind sadc_readout sadc_readout_monitor sadc_readout_monitor_inst (.*);

//--- tb_top.sv
// tb_top: self-checking bench for sadc_readout
// assumes the host model and the bound monitor
`timescale 1ns/1ps
module tb_top;
  logic clk_in, reset_n_in, convert_start_n_in, select_n_in;
  logic read_n_in, byte_sel_in, busy_out, result_bus_oe_out;
  logic input_connect_out, hold_out, avs_read, avs_write;
  logic avs_waitrequest, irq_out;
  logic [3:0] avs_address, avs_byteenable;
  logic [15:0] result_bus_out, sample_value_in, d, v;
  logic [31:0] avs_writedata, avs_readdata, q;
  integer seed, mismatches, samples_checked, cycles, n, last;
  sadc_readout sadc_readout_inst (.*);
  sadc_host_model sadc_host_model_inst (.clk_in(clk_in),
    .busy_in(busy_out), .oe_in(result_bus_oe_out),
    .data_in(result_bus_out), .convert_start_n_out(convert_start_n_in),
    .select_n_out(select_n_in), .read_n_out(read_n_in),
    .byte_sel_out(byte_sel_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_in);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    seed = 93;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    last = 0;
    reset_n_in <= 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    sample_value_in = 16'h0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    av(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    av(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < 12; i++) begin
      v = i == 0 ? 16'h0 : i == 1 ? 16'h8000 : i == 2 ? 16'hffff
        : i == 3 ? 16'h7fff : 16'($random(seed));
      av(1'b1, 4'h4, {31'h0, i[0]}, q);
      sample_value_in <= v;
      sadc_host_model_inst.start(4 + ($random(seed) & 3));
      sample_value_in <= ~v;
      sadc_host_model_inst.read_pins(1'b0, d);
      chk({16'h0, d}, last);
      sadc_host_model_inst.wait_done(n);
      chk(n + 3, sadc_pkg::CONV_CYCLES);
      last = v;
      sadc_host_model_inst.read_pins(1'b0, d);
      chk({16'h0, d}, last);
      sadc_host_model_inst.read_pins(1'b1, d);
      chk({16'h0, d}, {16'h0, v[7:0], 8'hff});
      av(1'b0, 4'h8, 32'h0, q);
      chk(q, {16'h0, v});
      chk({31'h0, irq_out}, {31'h0, i[0]});
      av(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h1);
      av(1'b1, 4'h0, 32'h1, q);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h0);
    end
    sadc_host_model_inst.start(4);
    sadc_host_model_inst.start(3);
    @(posedge clk_in);
    chk({31'h0, busy_out}, 32'h0);
    sadc_host_model_inst.start(1);
    sadc_host_model_inst.wait_done(n);
    chk(n, sadc_pkg::CONV_CYCLES);
    av(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h7);
    av(1'b0, 4'h8, 32'h0, q);
    chk(q, {16'h0, ~v});
    av(1'b1, 4'h0, 32'h7, q);
    sadc_host_model_inst.start(4);
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({31'h0, busy_out}, 32'h0);
    sadc_host_model_inst.read_pins(1'b0, d);
    chk({16'h0, d}, 32'h0);
    report_and_stop;
  end
endmodule : tb_top
